// ---- verilog/pma_address_generator.v ----
`include "pma_defines.vh"
`default_nettype none

// How it works
// - reads use read page, writes write page
// - page step only from paged pre/post modify
// - paged wrap sets address bit 15
// - overflow: page up, bit 15 set
// - underflow: page down, bit 15 set
// - offset, circular, bit-reverse: wrap within page
// - space edges: page kept, base space access
// - paged access with page zero traps
// - writes to program space trap
// - one circular buffer each in X, Y
// - any-length buffers: end checked going up, start going down
// - 16-bit start and end per space
// - Y circular math treats bit 0 zero
// - length from start/end, up to 32K words
// - X pointer field, enable bit 15
// - Y pointer field, enable bit 14
module pma_address_generator #(
  parameter PAGE_W = 10,
  parameter ADDR_W = 16
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // software writes of page and buffer registers
  input wire read_page_we,
  input wire write_page_we,
  input wire x_start_we,
  input wire x_end_we,
  input wire y_start_we,
  input wire y_end_we,
  input wire control_we,
  input wire [15:0] wr_data,
  // one address calculation request
  input wire req_valid,
  input wire req_write,
  input wire req_y_space,
  input wire [1:0] req_mode,
  input wire [3:0] req_pointer,
  input wire [ADDR_W-1:0] req_base,
  input wire signed [ADDR_W:0] req_step,
  // register state
  output reg [PAGE_W-1:0] read_page_select_q,
  output reg [PAGE_W-1:0] write_page_select_q,
  output reg [ADDR_W-1:0] x_buffer_start_q,
  output reg [ADDR_W-1:0] x_buffer_end_q,
  output reg [ADDR_W-1:0] y_buffer_start_q,
  output reg [ADDR_W-1:0] y_buffer_end_q,
  output reg [15:0] circular_addr_control_q,
  // calculation result
  output reg result_valid_q,
  output reg [ADDR_W-1:0] effective_address_q,
  output reg [PAGE_W-1:0] result_page_q,
  output reg base_space_q,
  output reg address_error_q
);

  // decoded control fields
  wire [3:0] x_pointer_select;
  wire [3:0] y_pointer_select;
  wire x_circular_enable;
  wire y_circular_enable;

  // access class
  reg paged_access;
  reg program_space_page;

  // circular buffer selection
  reg x_circ_hit;
  reg y_circ_hit;
  reg circ;
  reg [ADDR_W-1:0] cstart;
  reg [ADDR_W-1:0] cend;
  reg [ADDR_W-1:0] clen;
  reg [ADDR_W-1:0] cbase;
  reg [ADDR_W-1:0] circ_ea;

  // raw address arithmetic
  reg [ADDR_W:0] sum;
  reg [ADDR_W-1:0] raw_ea;
  reg step_zero;
  reg step_up;
  reg step_down;

  // page window crossing
  reg paged;
  reg pre_post;
  reg ovf;
  reg udf;

  // pages at the space boundaries
  reg at_eds_first;
  reg at_eds_last;
  reg at_psv_first_lsw;
  reg at_psv_last_lsw;
  reg at_psv_first_msw;
  reg at_psv_last_msw;
  reg to_base;

  // crossing outcome
  reg page_cross;
  reg wrap_in_page;
  reg psv_step_up;
  reg psv_step_down;
  reg page_up;
  reg page_down;

  // calculation outcome
  reg [PAGE_W-1:0] active_page_select;
  reg [PAGE_W-1:0] page_d;
  reg [ADDR_W-1:0] ea_d;
  reg base_d;
  reg page_zero_err;
  reg program_write_err;
  reg err_d;

  // page register updates
  reg read_page_step;
  reg write_page_step;

  assign x_pointer_select = circular_addr_control_q[`PMA_CTL_X_SEL_LSB +: 4];
  assign y_pointer_select = circular_addr_control_q[`PMA_CTL_Y_SEL_LSB +: 4];
  assign x_circular_enable = circular_addr_control_q[`PMA_CTL_X_EN_BIT];
  assign y_circular_enable = circular_addr_control_q[`PMA_CTL_Y_EN_BIT];

  // page register that serves this access
  always @* begin
    if (req_write)
      active_page_select = write_page_select_q;
    else
      active_page_select = read_page_select_q;
  end

  // access through the paged window, and a write page that maps program space
  always @* begin
    paged_access = req_base[`PMA_EA_WINDOW_BIT];
    program_space_page = write_page_select_q[PAGE_W-1];
  end

  // pointer match against the enabled buffer of the addressed space
  always @* begin
    x_circ_hit = x_circular_enable && (x_pointer_select != `PMA_SEL_NONE) &&
      (x_pointer_select == req_pointer);
    y_circ_hit = y_circular_enable && (y_pointer_select != `PMA_SEL_NONE) &&
      (y_pointer_select == req_pointer);
    if (req_y_space)
      circ = y_circ_hit;
    else
      circ = x_circ_hit; // X buffer also covers program-space pointers
  end

  // bounds and base of the selected buffer; only Y circular math is word aligned
  always @* begin
    cstart = x_buffer_start_q;
    cend = x_buffer_end_q;
    cbase = req_base;
    if (req_y_space) begin
      cstart = {y_buffer_start_q[ADDR_W-1:1], 1'b0};
      cend = {y_buffer_end_q[ADDR_W-1:1], 1'b0};
      if (circ)
        cbase = {req_base[ADDR_W-1:1], 1'b0};
    end
  end

  // length follows from the bounds; the last Y word covers two bytes
  always @* begin
    if (req_y_space)
      clen = cend - cstart + 16'h0002;
    else
      clen = cend - cstart + 16'h0001;
  end

  // signed step on the base; bit ADDR_W of the sum is the carry
  always @* begin
    sum = {1'b0, cbase} + req_step;
    raw_ea = sum[ADDR_W-1:0];
    step_zero = (req_step == {(ADDR_W+1){1'b0}});
    step_down = req_step[ADDR_W];
    step_up = !step_down && !step_zero;
  end

  // wrap past the end going up or past the start going down
  always @* begin
    circ_ea = raw_ea;
    if (step_up && (cbase <= cend) && (raw_ea > cend))
      circ_ea = raw_ea - clen;
    else if (step_down && (cbase >= cstart) && (raw_ea < cstart))
      circ_ea = raw_ea + clen;
  end

  // window crossings: bit 15 lost going up, or wrap below the window going down
  always @* begin
    paged = paged_access && !circ;
    pre_post = (req_mode == `PMA_MODE_PRE_POST);
    ovf = paged && step_up && !raw_ea[`PMA_EA_WINDOW_BIT];
    udf = paged && step_down && !raw_ea[`PMA_EA_WINDOW_BIT];
  end

  // crossings at the edges of the paged spaces
  always @* begin
    at_eds_first = (active_page_select == `PMA_PAGE_EDS_FIRST);
    at_eds_last = (active_page_select == `PMA_PAGE_EDS_LAST);
    at_psv_first_lsw = (active_page_select == `PMA_PAGE_PSV_FIRST_LSW);
    at_psv_last_lsw = (active_page_select == `PMA_PAGE_PSV_LAST_LSW);
    at_psv_first_msw = (active_page_select == `PMA_PAGE_PSV_FIRST_MSW);
    at_psv_last_msw = (active_page_select == `PMA_PAGE_PSV_LAST_MSW);
    to_base = (ovf && (at_eds_last || at_psv_last_msw)) ||
      (udf && (at_eds_first || at_psv_first_lsw));
  end

  // what a detected crossing does to the page and to bit 15
  always @* begin
    page_cross = (ovf || udf) && pre_post;
    wrap_in_page = (ovf || udf) && !pre_post;
    psv_step_up = page_cross && ovf && at_psv_last_lsw;
    psv_step_down = page_cross && udf && at_psv_first_msw;
    page_up = page_cross && ovf && !to_base && !at_psv_last_lsw;
    page_down = page_cross && udf && !to_base && !at_psv_first_msw;
  end

  // effective address, next page and base-space flag
  always @* begin
    ea_d = raw_ea;
    page_d = active_page_select;
    base_d = 1'b0;
    if (circ) begin
      ea_d = circ_ea;
      if (paged_access)
        ea_d[`PMA_EA_WINDOW_BIT] = 1'b1;
    end else if (wrap_in_page) begin
      ea_d[`PMA_EA_WINDOW_BIT] = 1'b1;
    end else if (page_cross) begin
      ea_d[`PMA_EA_WINDOW_BIT] = 1'b0;
      if (to_base)
        base_d = 1'b1;
      if (psv_step_up)
        page_d = `PMA_PAGE_PSV_FIRST_MSW;
      if (psv_step_down)
        page_d = `PMA_PAGE_PSV_LAST_LSW;
      if (page_up)
        page_d = active_page_select + 10'h001;
      if (page_down)
        page_d = active_page_select - 10'h001;
      if (!to_base)
        ea_d[`PMA_EA_WINDOW_BIT] = 1'b1;
    end
  end

  // traps: paged access through page zero, or a write into program space
  always @* begin
    page_zero_err = paged_access && (active_page_select == `PMA_PAGE_ZERO);
    program_write_err = req_write && paged_access && program_space_page;
    err_d = page_zero_err || program_write_err;
  end

  // a refused access leaves its page register alone
  always @* begin
    read_page_step = req_valid && !err_d && !req_write;
    write_page_step = req_valid && !err_d && req_write;
  end

  // one-cycle answer strobe and trap pulse
  always @(posedge clock) begin
    if (reset) begin
      result_valid_q <= 1'b0;
      address_error_q <= 1'b0;
    end else begin
      result_valid_q <= req_valid;
      address_error_q <= req_valid && err_d;
    end
  end

  // address, page and base-space flag stand until the next request
  always @(posedge clock) begin
    if (reset) begin
      effective_address_q <= `PMA_RST_WORD;
      result_page_q <= `PMA_RST_PAGE;
      base_space_q <= 1'b0;
    end else if (req_valid) begin
      effective_address_q <= ea_d;
      result_page_q <= page_d;
      base_space_q <= base_d;
    end
  end

  // read page; a hardware step in the same cycle wins over a software write
  always @(posedge clock) begin
    if (reset)
      read_page_select_q <= `PMA_RST_PAGE;
    else if (read_page_step)
      read_page_select_q <= page_d;
    else if (read_page_we)
      read_page_select_q <= wr_data[PAGE_W-1:0];
  end

  // write page; a hardware step in the same cycle wins over a software write
  always @(posedge clock) begin
    if (reset)
      write_page_select_q <= `PMA_RST_PAGE;
    else if (write_page_step)
      write_page_select_q <= page_d;
    else if (write_page_we)
      write_page_select_q <= wr_data[PAGE_W-1:0];
  end

  // start of the X buffer
  always @(posedge clock) begin
    if (reset)
      x_buffer_start_q <= `PMA_RST_WORD;
    else if (x_start_we)
      x_buffer_start_q <= wr_data;
  end

  // end of the X buffer
  always @(posedge clock) begin
    if (reset)
      x_buffer_end_q <= `PMA_RST_WORD;
    else if (x_end_we)
      x_buffer_end_q <= wr_data;
  end

  // start of the Y buffer
  always @(posedge clock) begin
    if (reset)
      y_buffer_start_q <= `PMA_RST_WORD;
    else if (y_start_we)
      y_buffer_start_q <= wr_data;
  end

  // end of the Y buffer
  always @(posedge clock) begin
    if (reset)
      y_buffer_end_q <= `PMA_RST_WORD;
    else if (y_end_we)
      y_buffer_end_q <= wr_data;
  end

  // circular pointer selects and enables
  always @(posedge clock) begin
    if (reset)
      circular_addr_control_q <= `PMA_RST_WORD;
    else if (control_we)
      circular_addr_control_q <= wr_data;
  end

endmodule // pma_address_generator
`default_nettype wire

// ---- verilog/pma_defines.vh ----
`ifndef PMA_DEFINES_VH
`define PMA_DEFINES_VH
// page numbers at the space boundaries
`define PMA_PAGE_ZERO 10'h000
`define PMA_PAGE_EDS_FIRST 10'h001
`define PMA_PAGE_EDS_LAST 10'h1FF
`define PMA_PAGE_PSV_FIRST_LSW 10'h200
`define PMA_PAGE_PSV_LAST_LSW 10'h2FF
`define PMA_PAGE_PSV_FIRST_MSW 10'h300
`define PMA_PAGE_PSV_LAST_MSW 10'h3FF
// effective address page-window bit
`define PMA_EA_WINDOW_BIT 15
// control word field positions
`define PMA_CTL_X_SEL_LSB 0
`define PMA_CTL_Y_SEL_LSB 4
`define PMA_CTL_Y_EN_BIT 14
`define PMA_CTL_X_EN_BIT 15
`define PMA_SEL_NONE 4'hF
// reset values
`define PMA_RST_PAGE 10'h001
`define PMA_RST_WORD 16'h0000
// addressing modes
`define PMA_MODE_PRE_POST 2'h0
`define PMA_MODE_REG_OFFSET 2'h1
`define PMA_MODE_BIT_REV 2'h2
`endif

// ---- verification/pma_checker.sv ----
`default_nettype none
module pma_checker (
  input wire logic clock, reset, req_valid, req_write, read_page_we, write_page_we,
  input wire logic [1:0] req_mode,
  input wire logic [15:0] req_base, effective_address_q, circular_addr_control_q,
  input wire logic signed [16:0] req_step,
  input wire logic [9:0] read_page_select_q, write_page_select_q,
  input wire logic result_valid_q, address_error_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [15:0] sum;
  logic [9:0] rp;
  assign sum = req_base + req_step[15:0];
  assign rp = read_page_select_q;
  sequence s_rd; req_valid && !req_write && !read_page_we && !write_page_we; endsequence
  sequence s_ovf; s_rd ##0 req_base[15] && !sum[15] && !req_step[16]; endsequence
  property p_ans; req_valid |=> result_valid_q; endproperty
  a_ans: assert property (p_ans) else $error("no result after request");
  property p_quiet; !req_valid |=> !result_valid_q && !address_error_q; endproperty
  a_quiet: assert property (p_quiet) else $error("result without request");
  property p_wpg; s_rd |=> $stable(write_page_select_q); endproperty
  a_wpg: assert property (p_wpg) else $error("read moved write page");
  property p_up;
    s_ovf ##0 req_mode == 2'h0 && circular_addr_control_q[15:14] == 2'h0
      && rp inside {[10'h001:10'h1FE]} |=> rp == $past(rp) + 10'h001 && effective_address_q[15];
  endproperty
  a_up: assert property (p_up) else $error("page not stepped up");
  property p_off; s_ovf ##0 req_mode == 2'h1 && rp != 10'h000 |=> $stable(rp) && effective_address_q[15]; endproperty
  a_off: assert property (p_off) else $error("offset wrap moved page");
  property p_edge;
    s_ovf ##0 req_mode == 2'h0 && rp == 10'h1FF && circular_addr_control_q[15:14] == 2'h0
      |=> $stable(rp) && !effective_address_q[15];
  endproperty
  a_edge: assert property (p_edge) else $error("last page crossing wrong");
  property p_zero; s_rd ##0 req_base[15] && rp == 10'h000 |=> address_error_q; endproperty
  a_zero: assert property (p_zero) else $error("page zero not trapped");
  property p_ps;
    req_valid && req_write && !write_page_we && req_base[15] && write_page_select_q[9]
      |=> address_error_q && $stable(write_page_select_q);
  endproperty
  a_ps: assert property (p_ps) else $error("program write not trapped");
endmodule // pma_checker
`default_nettype wire

// ---- verification/pma_exec_model.sv ----
`default_nettype none
// issues one request per go; fields scramble while idle
module pma_exec_model (
  input wire logic clock, go,
  input wire logic [40:0] cmd,
  output logic valid,
  output logic [40:0] fields
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(negedge clock) begin
    valid <= go;
    fields <= go ? cmd : ~fields;
  end
endmodule // pma_exec_model
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset = 1, go = 0, v, rv, bs, er;
  logic [6:0] we = 0;
  logic [15:0] d = 0, xs, xe, ys, ye, ctl, ea;
  logic [40:0] cmd = 0, f;
  logic [9:0] rp, wp, pg;
  int n_fail = 0, cmp_count = 0;
  always #50 clock = ~clock;
  pma_exec_model PM (.clock(clock), .go(go), .cmd(cmd), .valid(v), .fields(f));
  pma_address_generator DUT (.clock(clock), .reset(reset), .read_page_we(we[0]),
    .write_page_we(we[1]), .x_start_we(we[2]), .x_end_we(we[3]), .y_start_we(we[4]),
    .y_end_we(we[5]), .control_we(we[6]), .wr_data(d), .req_valid(v), .req_write(f[40]),
    .req_y_space(f[39]), .req_mode(f[38:37]), .req_pointer(f[36:33]), .req_base(f[32:17]),
    .req_step(f[16:0]), .read_page_select_q(rp), .write_page_select_q(wp),
    .x_buffer_start_q(xs), .x_buffer_end_q(xe), .y_buffer_start_q(ys), .y_buffer_end_q(ye),
    .circular_addr_control_q(ctl), .result_valid_q(rv), .effective_address_q(ea),
    .result_page_q(pg), .base_space_q(bs), .address_error_q(er));
  task stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input int i, input logic [15:0] x);
    @(negedge clock);
    we = 7'h01 << i;
    d = x;
    @(negedge clock);
    we = 7'h00;
  endtask
  task rq(input logic w, y, input logic [1:0] m, input logic [3:0] p,
      input logic [15:0] b, input logic [16:0] s);
    @(posedge clock);
    go = 1;
    cmd = {w, y, m, p, b, s};
    @(posedge clock);
    go = 0;
    @(negedge clock);
    chk("valid", 16'h0001, {15'h0000, rv});
  endtask
  task t_reset;
    chk("rp", 16'h0001, {6'h00, rp});
    chk("ctl", 16'h0000, ctl);
  endtask
  task t_pages;
    wr(0, 16'h0005);
    rq(0, 0, 2'h0, 4'h1, 16'hFFFE, 17'h00002);
    chk("ea", 16'h8000, ea);
    chk("rp", 16'h0006, {6'h00, rp});
    rq(0, 0, 2'h0, 4'h1, 16'h8000, 17'h1FFFE);
    chk("ea", 16'hFFFE, ea);
    chk("pg", 16'h0005, {6'h00, pg});
    rq(0, 0, 2'h1, 4'h1, 16'hFFFE, 17'h00002);
    chk("rp", 16'h0005, {6'h00, rp});
    chk("ea", 16'h8000, ea);
    rq(0, 0, 2'h2, 4'h1, 16'hFFFE, 17'h00002);
    chk("rp", 16'h0005, {6'h00, rp});
    chk("ea", 16'h8000, ea);
  endtask
  task t_edges;
    wr(0, 16'h01FF);
    rq(0, 0, 2'h0, 4'h1, 16'hFFFE, 17'h00002);
    chk("ea", 16'h0000, ea);
    chk("bs", 16'h0001, {15'h0000, bs});
    wr(0, 16'h02FF);
    rq(0, 0, 2'h0, 4'h1, 16'hFFFE, 17'h00002);
    chk("rp", 16'h0300, {6'h00, rp});
    chk("pg", 16'h0300, {6'h00, pg});
    chk("ea", 16'h8000, ea);
  endtask
  task t_write;
    wr(1, 16'h0005);
    rq(1, 0, 2'h0, 4'h1, 16'hFFFE, 17'h00002);
    chk("wp", 16'h0006, {6'h00, wp});
    wr(0, 16'h0000);
    rq(0, 0, 2'h0, 4'h1, 16'h8002, 17'h00002);
    chk("er", 16'h0001, {15'h0000, er});
    wr(1, 16'h0200);
    rq(1, 0, 2'h0, 4'h1, 16'h8002, 17'h00002);
    chk("er", 16'h0001, {15'h0000, er});
    chk("wp", 16'h0200, {6'h00, wp});
  endtask
  task t_circ;
    wr(2, 16'h1000);
    wr(3, 16'h100F);
    wr(6, 16'h8003);
    chk("xs", 16'h1000, xs);
    chk("xe", 16'h100F, xe);
    chk("ctl", 16'h8003, ctl);
    rq(0, 0, 2'h0, 4'h3, 16'h100E, 17'h00002);
    chk("ea", 16'h1000, ea);
    rq(0, 0, 2'h0, 4'h3, 16'h1000, 17'h1FFFE);
    chk("ea", 16'h100E, ea);
    rq(0, 0, 2'h0, 4'h4, 16'h100E, 17'h00002);
    chk("ea", 16'h1010, ea);
    wr(4, 16'h2000);
    wr(5, 16'h2007);
    chk("ys", 16'h2000, ys);
    chk("ye", 16'h2007, ye);
    wr(6, 16'h4030);
    rq(0, 1, 2'h0, 4'h3, 16'h2007, 17'h00002);
    chk("ea", 16'h2000, ea);
  endtask
  initial begin
    repeat (16) @(negedge clock);
    reset = 0;
    t_reset();
    t_pages();
    t_edges();
    t_write();
    t_circ();
    stop_test();
  end
  initial begin
    #60000;
    n_fail++;
    stop_test();
  end
endmodule // tb
bind pma_address_generator pma_checker CK (.*);
`default_nettype wire
